// ===== verilog/eeprom_write_pkg.sv
// Constants, register map and state codes for the data EEPROM write control
package eeprom_write_pkg;
	// Address map: sector in the high byte, low data-memory address below it
	localparam logic [7:0] CTRL_SECTOR   = 8'h01;
	localparam logic [7:0] CTRL_OFFSET   = 8'h40;
	localparam logic [7:0] COMMON_SECTOR = 8'h00;
	localparam logic [7:0] IND1_OFFSET   = 8'h00;
	localparam logic [7:0] PTR1L_OFFSET  = 8'h01;
	localparam logic [7:0] PTR1H_OFFSET  = 8'h02;
	localparam logic [7:0] IND2_OFFSET   = 8'h03;
	localparam logic [7:0] PTR2L_OFFSET  = 8'h04;
	localparam logic [7:0] PTR2H_OFFSET  = 8'h05;
	localparam logic [7:0] IRQ_OFFSET    = 8'h0e;
	localparam logic [7:0] LOC_OFFSET    = 8'h1e;
	localparam logic [7:0] BYTE_OFFSET   = 8'h1f;

	// Control register bit positions
	localparam int WPERMIT_BIT = 3;
	localparam int WSTART_BIT  = 2;
	localparam int RPERMIT_BIT = 1;
	localparam int RSTART_BIT  = 0;

	// Interrupt control register bit positions
	localparam int GIE_BIT     = 0;
	localparam int MFE_BIT     = 1;
	localparam int DONE_EN_BIT = 2;
	localparam int MF_REQ_BIT  = 4;
	localparam int DONE_REQ_BIT = 5;

	// Widths and reset values
	localparam int          LOC_W      = 7;
	localparam logic [7:0]  BYTE_RESET = 8'h00;
	localparam logic [6:0]  LOC_RESET  = 7'h00;
	localparam logic [7:0]  PTR_RESET  = 8'h00;
	localparam int          WRITE_TICKS_DEFAULT = 4;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_WRITE = 3'b010,
		ST_READ  = 3'b100
	} ctrl_state_t;
endpackage

// ===== verilog/eeprom_cell_array.sv
// Byte-wide EEPROM storage array with registered read data
`timescale 1ns/1ps
module eeprom_cell_array
#(
	parameter int ADDR_W = 7
)
(
	// Clock
	input  wire logic              core_clk_in,
	// Write port
	input  wire logic              wr_en_in,
	input  wire logic [ADDR_W-1:0] wr_addr_in,
	input  wire logic [7:0]        wr_data_in,
	// Read port
	input  wire logic              rd_en_in,
	input  wire logic [ADDR_W-1:0] rd_addr_in,
	output logic      [7:0]        rd_data_out
);
	logic [7:0] cell_mem [0:(1<<ADDR_W)-1];
	logic [7:0] rd_data_reg;

	// Cells keep content across reset, as nonvolatile storage should
	always_ff @(posedge core_clk_in)
	begin
		if (wr_en_in)
			cell_mem[wr_addr_in] <= wr_data_in;
		if (rd_en_in)
			rd_data_reg <= cell_mem[rd_addr_in];
	end

	assign rd_data_out = rd_data_reg;
endmodule

// ===== verilog/data_eeprom_write_control.sv
// Data EEPROM access control: sector-gated control register, timed write, done interrupt
// Functional notes
// - Write-start without write-permit already set is ignored; no cycle starts.
// - Write cycle is timed by ticks from an asynchronous timer, not core cycles.
// - Hardware clears write-start when the write cycle ends.
// - Reset clears write-permit.
// - Reset clears both pointer high bytes, selecting sector 0.
// - Write end sets the done request and the shared multi-function request.
// - Vector only with global, done and multi-function enables set, stack not full.
// - Servicing clears only the multi-function request; software clears done.
// - Control register sits at low address 40h of sector 1, via pointer.
// - Control: permit bit3, wstart bit2, rpermit bit1, rstart bit0; upper zero.
// - Location register is 7 bits; bit 7 reads zero.
// - Read-start with read-permit reads a byte; read-start then self-clears.
`timescale 1ns/1ps
module data_eeprom_write_control
	import eeprom_write_pkg::*;
#(
	parameter int WRITE_TICKS = eeprom_write_pkg::WRITE_TICKS_DEFAULT
)
(
	// Clock and reset
	input  wire logic       core_clk_in,
	input  wire logic       reset_in,
	// Data-memory access port of the core
	input  wire logic [7:0] cpu_addr_in,
	input  wire logic       cpu_wr_in,
	input  wire logic       cpu_rd_in,
	input  wire logic [7:0] cpu_wdata_in,
	output logic      [7:0] cpu_rdata_out,
	// Asynchronous write timer
	input  wire logic       write_tick_in,
	// Interrupt
	input  wire logic       stack_full_in,
	output logic            irq_vector_out
);
	import eeprom_write_pkg::*;

	ctrl_state_t state_reg, state_next;
	logic [LOC_W-1:0] loc_reg, loc_next;
	logic [7:0] byte_reg, byte_next;
	logic [7:0] p1l_reg, p1l_next, p1h_reg, p1h_next;
	logic [7:0] p2l_reg, p2l_next, p2h_reg, p2h_next;
	logic       wpermit_reg, wpermit_next, wstart_reg, wstart_next;
	logic       rpermit_reg, rpermit_next, rstart_reg, rstart_next;
	logic       gie_reg, gie_next, mfe_reg, mfe_next, done_en_reg, done_en_next;
	logic       mf_req_reg, mf_req_next, done_req_reg, done_req_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] tick_cnt_reg, tick_cnt_next;
	logic       tick_s1_reg, tick_s2_reg, tick_prev_reg;
	logic       tick_edge, mem_we, mem_re, irq_take;
	logic [15:0] wr_key, rd_key;
	logic [7:0]  mem_rdata;

	// Sector-qualified address; indirect ports take their pointer pair
	function automatic logic [15:0] resolve(input logic [7:0] a, input logic [7:0] h1,
		input logic [7:0] l1, input logic [7:0] h2, input logic [7:0] l2);
		if (a == IND1_OFFSET)
			resolve = {h1, l1};
		else if (a == IND2_OFFSET)
			resolve = {h2, l2};
		else
			resolve = {COMMON_SECTOR, a};
	endfunction

	assign wr_key = resolve(cpu_addr_in, p1h_reg, p1l_reg, p2h_reg, p2l_reg);
	assign rd_key = resolve(cpu_addr_in, p1h_reg, p1l_reg, p2h_reg, p2l_reg);

	// Timer pin is asynchronous; edge detect only after the second flop
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			tick_s1_reg   <= 1'b0;
			tick_s2_reg   <= 1'b0;
			tick_prev_reg <= 1'b0;
		end
		else
		begin
			tick_s1_reg   <= write_tick_in;
			tick_s2_reg   <= tick_s1_reg;
			tick_prev_reg <= tick_s2_reg;
		end
	end
	assign tick_edge = tick_s2_reg & ~tick_prev_reg;

	// Vector needs every enable and room on the stack
	assign irq_take = gie_reg & mfe_reg & done_en_reg & mf_req_reg & ~stack_full_in;
	assign irq_vector_out = irq_take;

	// Next-state logic for registers, sequencer and read data
	always_comb
	begin
		state_next    = state_reg;
		loc_next      = loc_reg;
		byte_next     = byte_reg;
		p1l_next      = p1l_reg;
		p1h_next      = p1h_reg;
		p2l_next      = p2l_reg;
		p2h_next      = p2h_reg;
		wpermit_next  = wpermit_reg;
		wstart_next   = wstart_reg;
		rpermit_next  = rpermit_reg;
		rstart_next   = rstart_reg;
		gie_next      = gie_reg;
		mfe_next      = mfe_reg;
		done_en_next  = done_en_reg;
		mf_req_next   = mf_req_reg;
		done_req_next = done_req_reg;
		tick_cnt_next = tick_cnt_reg;
		rdata_next    = rdata_reg;
		mem_we        = 1'b0;
		mem_re        = 1'b0;
		// Vectoring masks further entries and clears the shared request only
		if (irq_take)
		begin
			mf_req_next = 1'b0;
			gie_next    = 1'b0;
		end
		// Software writes
		if (cpu_wr_in)
		begin
			unique case (wr_key)
				{COMMON_SECTOR, LOC_OFFSET}:   loc_next = cpu_wdata_in[LOC_W-1:0];
				{COMMON_SECTOR, BYTE_OFFSET}:  byte_next = cpu_wdata_in;
				{COMMON_SECTOR, PTR1L_OFFSET}: p1l_next = cpu_wdata_in;
				{COMMON_SECTOR, PTR1H_OFFSET}: p1h_next = cpu_wdata_in;
				{COMMON_SECTOR, PTR2L_OFFSET}: p2l_next = cpu_wdata_in;
				{COMMON_SECTOR, PTR2H_OFFSET}: p2h_next = cpu_wdata_in;
				{COMMON_SECTOR, IRQ_OFFSET}:
				begin
					gie_next      = cpu_wdata_in[GIE_BIT];
					mfe_next      = cpu_wdata_in[MFE_BIT];
					done_en_next  = cpu_wdata_in[DONE_EN_BIT];
					mf_req_next   = cpu_wdata_in[MF_REQ_BIT];
					done_req_next = cpu_wdata_in[DONE_REQ_BIT];
				end
				{CTRL_SECTOR, CTRL_OFFSET}:
				begin
					wpermit_next = cpu_wdata_in[WPERMIT_BIT];
					rpermit_next = cpu_wdata_in[RPERMIT_BIT];
					// Starts use permit bits as they stood before this write
					if (state_reg == ST_IDLE)
					begin
						if (cpu_wdata_in[WSTART_BIT] && wpermit_reg)
						begin
							wstart_next   = 1'b1;
							tick_cnt_next = 8'h00;
							state_next    = ST_WRITE;
						end
						else if (cpu_wdata_in[RSTART_BIT] && rpermit_reg)
						begin
							rstart_next = 1'b1;
							mem_re      = 1'b1;
							state_next  = ST_READ;
						end
					end
				end
				default: ;
			endcase
		end
		// Sequencer; hardware events come last so a set beats a software clear
		unique case (state_reg)
			ST_IDLE: ;
			ST_WRITE:
			begin
				wstart_next = 1'b1;
				if (tick_edge)
				begin
					if (tick_cnt_reg == 8'(WRITE_TICKS - 1))
					begin
						mem_we        = 1'b1;
						wstart_next   = 1'b0;
						done_req_next = 1'b1;
						mf_req_next   = 1'b1;
						state_next    = ST_IDLE;
					end
					else
						tick_cnt_next = tick_cnt_reg + 8'h01;
				end
			end
			ST_READ:
			begin
				byte_next   = mem_rdata;
				rstart_next = 1'b0;
				state_next  = ST_IDLE;
			end
		endcase
		// Registered read data; unmapped addresses read zero
		if (cpu_rd_in)
		begin
			unique case (rd_key)
				{COMMON_SECTOR, LOC_OFFSET}:   rdata_next = {1'b0, loc_reg};
				{COMMON_SECTOR, BYTE_OFFSET}:  rdata_next = byte_reg;
				{COMMON_SECTOR, PTR1L_OFFSET}: rdata_next = p1l_reg;
				{COMMON_SECTOR, PTR1H_OFFSET}: rdata_next = p1h_reg;
				{COMMON_SECTOR, PTR2L_OFFSET}: rdata_next = p2l_reg;
				{COMMON_SECTOR, PTR2H_OFFSET}: rdata_next = p2h_reg;
				{COMMON_SECTOR, IRQ_OFFSET}:
					rdata_next = {2'b00, done_req_reg, mf_req_reg, 1'b0,
						done_en_reg, mfe_reg, gie_reg};
				{CTRL_SECTOR, CTRL_OFFSET}:
					rdata_next = {4'h0, wpermit_reg, wstart_reg, rpermit_reg, rstart_reg};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// State registers
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			state_reg    <= ST_IDLE;
			loc_reg      <= LOC_RESET;
			byte_reg     <= BYTE_RESET;
			p1l_reg      <= PTR_RESET;
			p1h_reg      <= PTR_RESET;
			p2l_reg      <= PTR_RESET;
			p2h_reg      <= PTR_RESET;
			wpermit_reg  <= 1'b0;
			wstart_reg   <= 1'b0;
			rpermit_reg  <= 1'b0;
			rstart_reg   <= 1'b0;
			gie_reg      <= 1'b0;
			mfe_reg      <= 1'b0;
			done_en_reg  <= 1'b0;
			mf_req_reg   <= 1'b0;
			done_req_reg <= 1'b0;
			tick_cnt_reg <= 8'h00;
			rdata_reg    <= 8'h00;
		end
		else
		begin
			state_reg    <= state_next;
			loc_reg      <= loc_next;
			byte_reg     <= byte_next;
			p1l_reg      <= p1l_next;
			p1h_reg      <= p1h_next;
			p2l_reg      <= p2l_next;
			p2h_reg      <= p2h_next;
			wpermit_reg  <= wpermit_next;
			wstart_reg   <= wstart_next;
			rpermit_reg  <= rpermit_next;
			rstart_reg   <= rstart_next;
			gie_reg      <= gie_next;
			mfe_reg      <= mfe_next;
			done_en_reg  <= done_en_next;
			mf_req_reg   <= mf_req_next;
			done_req_reg <= done_req_next;
			tick_cnt_reg <= tick_cnt_next;
			rdata_reg    <= rdata_next;
		end
	end

	assign cpu_rdata_out = rdata_reg;

	// Storage: live location and byte registers feed the write at cycle end
	eeprom_cell_array #(.ADDR_W(LOC_W)) u_cells
	(
		.core_clk_in (core_clk_in),
		.wr_en_in    (mem_we),
		.wr_addr_in  (loc_reg),
		.wr_data_in  (byte_reg),
		.rd_en_in    (mem_re),
		.rd_addr_in  (loc_reg),
		.rd_data_out (mem_rdata)
	);

	// Checks
	default clocking cb @(posedge core_clk_in); endclocking

	logic ctrl_wr;
	assign ctrl_wr = cpu_wr_in && (wr_key == {CTRL_SECTOR, CTRL_OFFSET});

	AST_START_NEEDS_PERMIT: assert property (disable iff (reset_in)
		ctrl_wr && cpu_wdata_in[WSTART_BIT] && !wpermit_reg && state_reg == ST_IDLE
		|=> state_reg != ST_WRITE && !wstart_reg)
		else $error("write started without permit");
	AST_WRITE_WAITS_TICK: assert property (disable iff (reset_in)
		state_reg == ST_WRITE && !tick_edge |=> state_reg == ST_WRITE)
		else $error("write ended without a timer tick");
	AST_WSTART_CLEARS: assert property (disable iff (reset_in)
		mem_we |=> !wstart_reg && state_reg == ST_IDLE)
		else $error("write-start not cleared at write end");
	AST_RESET_STATE: assert property (
		reset_in |=> !wpermit_reg && p1h_reg == PTR_RESET && p2h_reg == PTR_RESET)
		else $error("reset left write permit or pointer high set");
	AST_DONE_FLAGS: assert property (disable iff (reset_in)
		mem_we |=> done_req_reg && mf_req_reg)
		else $error("done flags not set at write end");
	AST_VECTOR_GATED: assert property (disable iff (reset_in)
		irq_vector_out |-> gie_reg && mfe_reg && done_en_reg && !stack_full_in)
		else $error("vector taken with an enable missing");
	AST_SERVICE_CLEARS: assert property (disable iff (reset_in)
		irq_vector_out && !mem_we && !cpu_wr_in
		|=> !mf_req_reg && done_req_reg == $past(done_req_reg))
		else $error("servicing cleared the wrong flag");
	AST_DIRECT_40_NO_CTRL: assert property (disable iff (reset_in)
		cpu_wr_in && cpu_addr_in == CTRL_OFFSET |=> $stable(wpermit_reg))
		else $error("control reached without sector pointer");
	AST_LOC_BIT7_ZERO: assert property (disable iff (reset_in)
		cpu_rd_in && rd_key == {COMMON_SECTOR, LOC_OFFSET} |=> !cpu_rdata_out[7])
		else $error("location bit 7 read as one");
	AST_READ_DONE: assert property (disable iff (reset_in)
		state_reg == ST_READ |=> !rstart_reg && byte_reg == $past(mem_rdata))
		else $error("read did not complete in one cycle");
	AST_BUSY_HOLDS: assert property (disable iff (reset_in)
		state_reg == ST_WRITE |-> wstart_reg)
		else $error("write-start dropped during write");

	COV_WRITE_DONE: cover property (disable iff (reset_in) mem_we);
	COV_READ_DONE: cover property (disable iff (reset_in) state_reg == ST_READ);
	COV_VECTOR: cover property (disable iff (reset_in) irq_vector_out);
endmodule

// ===== verif/data_eeprom_write_control_tb.sv
// Self-checking bench for the data EEPROM write control block
`timescale 1ns/1ps
module data_eeprom_write_control_tb;
	import eeprom_write_pkg::*;
	// Short write timer keeps each write cycle brief
	localparam int TICKS = 2;
	logic       core_clk_in;
	logic       reset_in;
	logic [7:0] cpu_addr_in;
	logic       cpu_wr_in;
	logic       cpu_rd_in;
	logic [7:0] cpu_wdata_in;
	logic [7:0] cpu_rdata_out;
	logic       write_tick_in;
	logic       stack_full_in;
	logic       irq_vector_out;
	int         fail_count = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	int         hits;
	logic [7:0] val;

	data_eeprom_write_control #(.WRITE_TICKS(TICKS)) i_data_eeprom_write_control
	(
		.core_clk_in    (core_clk_in),
		.reset_in       (reset_in),
		.cpu_addr_in    (cpu_addr_in),
		.cpu_wr_in      (cpu_wr_in),
		.cpu_rd_in      (cpu_rd_in),
		.cpu_wdata_in   (cpu_wdata_in),
		.cpu_rdata_out  (cpu_rdata_out),
		.write_tick_in  (write_tick_in),
		.stack_full_in  (stack_full_in),
		.irq_vector_out (irq_vector_out)
	);

	// Core clock, 4 ns period
	initial
	begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end

	// Slow write timer, free running; half-ns offset keeps its edges off every core edge
	initial
	begin
		write_tick_in = 1'b0;
		#7.5;
		forever #19 write_tick_in = ~write_tick_in;
	end

	// Hang guard; a full run needs well under a thousand cycles
	always @(posedge core_clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fail_count = fail_count + 1;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One core write; strobe dropped at the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		cpu_addr_in  <= a;
		cpu_wdata_in <= d;
		cpu_wr_in    <= 1'b1;
		@(posedge core_clk_in);
		cpu_wr_in    <= 1'b0;
	endtask

	// One core read; data is registered, so sample just after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_in);
		cpu_addr_in <= a;
		cpu_rd_in   <= 1'b1;
		@(posedge core_clk_in);
		cpu_rd_in   <= 1'b0;
		#1;
		d = cpu_rdata_out;
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check(what, d, exp);
	endtask

	// Vector pulses are one cycle wide, so look before every edge
	task automatic count_vec(input int n, output int h);
		h = 0;
		repeat (n)
		begin
			#1;
			if (irq_vector_out === 1'b1)
				h++;
			@(posedge core_clk_in);
		end
	endtask

	// Pointer one aimed at the control register in sector 1
	task automatic point_ctrl();
		wr(PTR1L_OFFSET, CTRL_OFFSET);
		wr(PTR1H_OFFSET, CTRL_SECTOR);
	endtask

	task automatic t_reset();
		rdchk("ptr1 high", PTR1H_OFFSET, 8'h00);
		rdchk("ptr2 high", PTR2H_OFFSET, 8'h00);
		rdchk("direct 40h", CTRL_OFFSET, 8'h00);
		wr(LOC_OFFSET, 8'hff);
		rdchk("location", LOC_OFFSET, 8'h7f);
		point_ctrl();
		rdchk("ctrl reset", IND1_OFFSET, 8'h00);
	endtask

	task automatic t_no_permit();
		wr(IND1_OFFSET, 8'h04);
		rdchk("start alone", IND1_OFFSET, 8'h00);
		rdchk("no done", IRQ_OFFSET, 8'h00);
		wr(CTRL_OFFSET, 8'h08);
		rdchk("sector 0 write", IND1_OFFSET, 8'h00);
		wr(IND1_OFFSET, 8'hf2);
		rdchk("upper bits", IND1_OFFSET, 8'h02);
		wr(IND1_OFFSET, 8'h00);
	endtask

	task automatic t_write();
		int polls;
		wr(BYTE_OFFSET, 8'ha5);
		wr(LOC_OFFSET, 8'h12);
		wr(IRQ_OFFSET, 8'h06);
		wr(IND1_OFFSET, 8'h08);
		wr(IND1_OFFSET, 8'h0c);
		// Global enable only once the cycle has begun
		wr(IRQ_OFFSET, 8'h07);
		rdchk("busy", IND1_OFFSET, 8'h0c);
		polls = 0;
		val = 8'h04;
		while (val[WSTART_BIT] !== 1'b0 && polls < 100)
		begin
			rd(IND1_OFFSET, val);
			polls++;
		end
		check("write end", val, 8'h08);
		rdchk("requests", IRQ_OFFSET, 8'h37);
		wr(IND1_OFFSET, 8'h00);
		// Read back through a fresh read cycle
		wr(BYTE_OFFSET, 8'h00);
		wr(LOC_OFFSET, 8'h12);
		wr(IND1_OFFSET, 8'h02);
		wr(IND1_OFFSET, 8'h03);
		rdchk("read back", BYTE_OFFSET, 8'ha5);
		rdchk("read end", IND1_OFFSET, 8'h02);
	endtask

	task automatic t_irq();
		logic [7:0] masks [3] = '{8'h36, 8'h35, 8'h33};
		count_vec(5, hits);
		check("stack full", 8'(hits), 8'h00);
		@(posedge core_clk_in);
		stack_full_in <= 1'b0;
		count_vec(4, hits);
		check("vector", 8'(hits), 8'h01);
		rdchk("serviced", IRQ_OFFSET, 8'h26);
		foreach (masks[i])
		begin
			wr(IRQ_OFFSET, masks[i]);
			count_vec(4, hits);
			check("masked", 8'(hits), 8'h00);
		end
		wr(IRQ_OFFSET, 8'h37);
		count_vec(4, hits);
		check("revector", 8'(hits), 8'h01);
		// Software clears the done request itself
		wr(IRQ_OFFSET, 8'h06);
		rdchk("done cleared", IRQ_OFFSET, 8'h06);
	endtask

	// Main sequence
	initial
	begin
		reset_in      = 1'b1;
		cpu_addr_in   = 8'h00;
		cpu_wr_in     = 1'b0;
		cpu_rd_in     = 1'b0;
		cpu_wdata_in  = 8'h00;
		stack_full_in = 1'b1;
		repeat (3) @(posedge core_clk_in);
		reset_in <= 1'b0;
		t_reset();
		t_no_permit();
		t_write();
		t_irq();
		// Second reset with permit left set
		wr(IND1_OFFSET, 8'h08);
		@(posedge core_clk_in);
		reset_in <= 1'b1;
		@(posedge core_clk_in);
		reset_in <= 1'b0;
		t_reset();
		wrap_up();
	end
endmodule
